// *** hdl/asc_scan_control.sv ***
`timescale 1ns/10ps
// Functional notes
// - Oscillator runs in timing modes 00, 01, 10
// - Mode 11 times conversions from serial clock
// - Reference route code steers ADC and DAC
// - Secondary reference pin is input for 00/10
// - Command bit 0 requests one temperature reading
// - Temperature is high-bias minus low-bias minus offset
// - Temperature always uses internal reference
// - Temperature converts first in its scan
// - Newer temperature replaces an unread one
// - Bit 7 set decodes as conversion command
// - Sweep bits select scan range or repeat
// - Repeat count comes from averaging bits
// - One result per channel or pair, one per repeat in mode 10
// - Modes 10/11 start on write, else pin
// - Skip channels used as start or reference
// - Pairs ignore lowest channel bit
// - Setup bits set timing and pair config
// - Reference stays on when forced, or when DAC needs it in route 00
// - Start pin role depends on timing mode
// - Upper timing bit set at power-up
// - Wait 244 clocks for reference to wake
// - Result word: four zeros, then 12 data bits
module asc_scan_control
	import asc_pkg::*;
#(
	parameter int NUM_CHANNELS = 16
)
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	output logic o_dout,
	input wire logic i_convert_start_pin_n,
	input wire logic [1:0] i_repeat_count,
	input wire logic i_bandgap_force_on,
	input wire logic i_dac_ref_demand,
	input wire logic [7:0] i_pair_enable,
	input wire logic i_conv_done,
	input wire logic [11:0] i_conv_data,
	input wire logic [15:0] i_fifo_word,
	input wire logic i_fifo_empty,
	output logic o_osc_enable,
	output logic o_ext_clock_timing,
	output logic o_convert_start_pin_active,
	output logic o_acq_by_pin,
	output logic o_adc_ref_internal,
	output logic o_adc_ref_secondary,
	output logic o_adc_ref_differential,
	output logic o_dac_ref_external,
	output logic o_secondary_pin_is_input,
	output logic o_ref_keep_on,
	output logic [1:0] o_pair_config,
	output logic o_conv_start,
	output logic [3:0] o_conv_channel,
	output logic o_conv_diff,
	output logic o_conv_temp,
	output logic o_temp_bias_high,
	output logic o_fifo_push,
	output logic [15:0] o_fifo_data,
	output logic o_fifo_pop,
	output logic o_busy
);
	// ======================================================================
	// Sequencer states
	// ======================================================================
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WAKE = 5'b00010,
		ST_TEMP_HI = 5'b00100,
		ST_TEMP_LO = 5'b01000,
		ST_CHAN = 5'b10000
	} asc_state_t;

	asc_state_t state_q; // Sequencer state
	logic [1:0] timing_mode_q; // Setup bits 5:4
	logic [1:0] reference_route_q; // Setup bits 3:2
	logic [1:0] pair_config_q; // Setup bits 1:0
	logic [3:0] channel_pick_q; // Conversion bits 6:3
	logic [1:0] sweep_mode_q; // Conversion bits 2:1
	logic temp_req_q; // Conversion bit 0
	logic [7:0] link_rx_byte; // Held byte from link domain
	logic link_rx_toggle;
	logic link_pop_toggle;
	logic [2:0] rx_sync_q; // Two sync flops plus edge history
	logic [2:0] pop_sync_q;
	logic [2:0] pin_sync_q; // Start pin sync plus history
	logic rx_event;
	logic pop_event;
	logic pin_fall;
	logic conv_write;
	logic setup_write;
	logic scan_go;
	logic conv_go_q; // Command taken, scan starts a cycle later
	logic [4:0] ch_q; // Current channel, one extra bit for overflow
	logic [4:0] last_q; // Last channel of range
	logic [4:0] repeat_q; // Conversions left in repeat mode
	logic busy_q; // Conversion in flight
	logic [7:0] wake_q; // Reference settle counter
	logic [11:0] temp_hi_q; // High-bias raw reading
	logic [11:0] temp_q; // Finished temperature
	logic temp_valid_q; // Temperature waiting to be read
	logic temp_done; // Temperature finished this cycle
	logic [15:0] tx_word_q; // Word offered to the link
	logic ch_skip;
	logic [4:0] ch_eff; // Channel with pair bit folded

	// ======================================================================
	// Serial link, clocked by the host serial clock
	// ======================================================================
	// Link logic relies on host keeping its clock within range
	asc_serial_link u_link (
		.i_link_clk(i_sclk),
		.i_reset_n(i_reset_n),
		.i_cs_n(i_cs_n),
		.i_din(i_din),
		.i_tx_word(tx_word_q),
		.o_dout(o_dout),
		.o_rx_byte(link_rx_byte),
		.o_rx_toggle(link_rx_toggle),
		.o_pop_toggle(link_pop_toggle)
	);

	// ======================================================================
	// Crossings into the core domain
	// ======================================================================
	// Toggles and the pin pass two flops before any edge detection
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_sync_q <= 3'h0;
			pop_sync_q <= 3'h0;
			pin_sync_q <= 3'h7;
			conv_go_q <= 1'b0;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], link_rx_toggle};
			pop_sync_q <= {pop_sync_q[1:0], link_pop_toggle};
			pin_sync_q <= {pin_sync_q[1:0], i_convert_start_pin_n};
			// Delay lets the sequencer see the freshly stored command
			conv_go_q <= conv_write && (state_q == ST_IDLE);
		end
	end

	assign rx_event = rx_sync_q[2] ^ rx_sync_q[1];
	assign pop_event = pop_sync_q[2] ^ pop_sync_q[1];
	assign pin_fall = pin_sync_q[2] & ~pin_sync_q[1];
	// Byte is stable: the link holds it until the next frame
	assign conv_write = rx_event & link_rx_byte[CMD_CONV_BIT];
	assign setup_write = rx_event &
		(link_rx_byte[CMD_SETUP_HI -: 2] == CMD_SETUP_TAG);

	// ======================================================================
	// Setup command register
	// ======================================================================
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			timing_mode_q <= TIMING_RESET;
			reference_route_q <= REF_RESET;
			pair_config_q <= PAIR_RESET;
		end else if (setup_write) begin
			timing_mode_q <= link_rx_byte[SETUP_TIMING_LSB +: 2];
			reference_route_q <= link_rx_byte[SETUP_REF_LSB +: 2];
			pair_config_q <= link_rx_byte[SETUP_PAIR_LSB +: 2];
		end
	end

	// ======================================================================
	// Conversion command register
	// ======================================================================
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			channel_pick_q <= CHAN_RESET;
			sweep_mode_q <= SWEEP_RESET;
			temp_req_q <= 1'b0;
		end else if (conv_write && state_q == ST_IDLE) begin
			channel_pick_q <= link_rx_byte[CONV_CHAN_LSB +: 4];
			sweep_mode_q <= link_rx_byte[CONV_SWEEP_LSB +: 2];
			temp_req_q <= link_rx_byte[CONV_TEMP_BIT];
		end
	end

	// ======================================================================
	// Clock and reference routing
	// ======================================================================
	assign o_osc_enable = (timing_mode_q != TIMING_EXT);
	assign o_ext_clock_timing = (timing_mode_q == TIMING_EXT);
	// Pin only a start input in the two lower timing modes
	assign o_convert_start_pin_active = ~timing_mode_q[1];
	assign o_acq_by_pin = (timing_mode_q == TIMING_INT_PIN);
	assign o_adc_ref_internal = ~reference_route_q[0];
	assign o_adc_ref_secondary = (reference_route_q == REF_EXT_SINGLE);
	assign o_adc_ref_differential = (reference_route_q == REF_EXT_DIFF);
	assign o_dac_ref_external = (reference_route_q != REF_INT_BOTH);
	assign o_secondary_pin_is_input = ~reference_route_q[0];
	assign o_ref_keep_on = i_bandgap_force_on |
		((reference_route_q == REF_INT_BOTH) & i_dac_ref_demand);
	assign o_pair_config = pair_config_q;

	// ======================================================================
	// Scan start
	// ======================================================================
	// Command-started modes use the write; pin modes use a low pulse
	assign scan_go = (state_q == ST_IDLE) &&
		(timing_mode_q[1] ? conv_go_q : pin_fall);

	// ======================================================================
	// Channel screening
	// ======================================================================
	// Pair members fold onto the even channel of the pair
	always_comb begin
		ch_eff = ch_q;
		if (i_pair_enable[ch_q[3:1]]) begin
			ch_eff = {ch_q[4:1], 1'b0};
		end
	end

	// Pins lent to the start or reference roles are never converted
	always_comb begin
		logic [4:0] start_pin;
		logic [4:0] ref_pin;
		start_pin = 5'(NUM_CHANNELS - 1);
		ref_pin = 5'(NUM_CHANNELS - 2);
		ch_skip = 1'b0;
		if (ch_q >= 5'(NUM_CHANNELS)) begin
			ch_skip = 1'b1;
		end else if (i_pair_enable[ch_q[3:1]]) begin
			// Pair counts once; either pin lent kills the pair
			if (ch_q[0] && sweep_mode_q[1] == 1'b0) begin
				ch_skip = 1'b1;
			end else if (~timing_mode_q[1] && ch_q[4:1] == start_pin[4:1]) begin
				ch_skip = 1'b1;
			end else if (reference_route_q[0] && ch_q[4:1] == ref_pin[4:1]) begin
				ch_skip = 1'b1;
			end
		end else if (~timing_mode_q[1] && ch_q == start_pin) begin
			ch_skip = 1'b1;
		end else if (reference_route_q[0] && ch_q == ref_pin) begin
			ch_skip = 1'b1;
		end
	end

	// ======================================================================
	// Scan sequencer
	// ======================================================================
	// One conversion at a time; waits for the converter's done pulse
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= ST_IDLE;
			ch_q <= 5'h00;
			last_q <= 5'h00;
			repeat_q <= 5'h00;
			busy_q <= 1'b0;
			wake_q <= 8'h00;
			temp_hi_q <= 12'h000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					busy_q <= 1'b0;
					if (scan_go) begin
						case (sweep_mode_q)
							SWEEP_UP_TO_N: begin
								ch_q <= 5'h00;
								last_q <= {1'b0, channel_pick_q};
							end
							SWEEP_N_TO_TOP: begin
								ch_q <= {1'b0, channel_pick_q};
								last_q <= 5'(NUM_CHANNELS - 1);
							end
							default: begin
								ch_q <= {1'b0, channel_pick_q};
								last_q <= {1'b0, channel_pick_q};
							end
						endcase
						// Repeat counts only apply to mode 10
						if (sweep_mode_q == SWEEP_REPEAT) begin
							case (i_repeat_count)
								2'h0: repeat_q <= REPEAT_0;
								2'h1: repeat_q <= REPEAT_1;
								2'h2: repeat_q <= REPEAT_2;
								default: repeat_q <= REPEAT_3;
							endcase
						end else begin
							repeat_q <= 5'h01;
						end
						wake_q <= REF_WAKE_CYCLES;
						// Temperature runs ahead of every channel
						if (temp_req_q && !o_ref_keep_on) begin
							state_q <= ST_WAKE;
						end else if (temp_req_q) begin
							state_q <= ST_TEMP_HI;
						end else begin
							state_q <= ST_CHAN;
						end
					end
				end
				ST_WAKE: begin
					// Reference was asleep; let it settle first
					if (wake_q == 8'h01) begin
						state_q <= ST_TEMP_HI;
					end
					wake_q <= wake_q - 8'h01;
				end
				ST_TEMP_HI: begin
					if (!busy_q) begin
						busy_q <= 1'b1;
					end else if (i_conv_done) begin
						temp_hi_q <= i_conv_data;
						busy_q <= 1'b0;
						state_q <= ST_TEMP_LO;
					end
				end
				ST_TEMP_LO: begin
					if (!busy_q) begin
						busy_q <= 1'b1;
					end else if (i_conv_done) begin
						busy_q <= 1'b0;
						state_q <= ST_CHAN;
					end
				end
				ST_CHAN: begin
					if (ch_skip && !busy_q) begin
						// Skipped channel yields nothing; move on
						if (ch_q >= last_q) begin
							state_q <= ST_IDLE;
						end else begin
							ch_q <= ch_q + 5'h01;
						end
					end else if (!busy_q) begin
						busy_q <= 1'b1;
					end else if (i_conv_done) begin
						busy_q <= 1'b0;
						if (repeat_q > 5'h01) begin
							repeat_q <= repeat_q - 5'h01;
						end else if (ch_q >= last_q) begin
							state_q <= ST_IDLE;
						end else begin
							ch_q <= ch_q + 5'h01;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// Converter request outputs
	// ======================================================================
	// Start pulse in the cycle that the sequencer raises busy
	assign o_conv_start = !busy_q &&
		(state_q == ST_TEMP_HI || state_q == ST_TEMP_LO ||
		(state_q == ST_CHAN && !ch_skip));
	assign o_conv_channel = ch_eff[3:0];
	assign o_conv_diff = i_pair_enable[ch_q[3:1]];
	// Temperature ignores the reference route setting
	assign o_conv_temp = (state_q == ST_TEMP_HI) || (state_q == ST_TEMP_LO);
	assign o_temp_bias_high = (state_q == ST_TEMP_HI);
	assign o_busy = (state_q != ST_IDLE);
	assign temp_done = (state_q == ST_TEMP_LO) && busy_q && i_conv_done;

	// ======================================================================
	// Channel results into the external buffer
	// ======================================================================
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fifo_push <= 1'b0;
			o_fifo_data <= 16'h0000;
		end else begin
			o_fifo_push <= (state_q == ST_CHAN) && busy_q && i_conv_done;
			if ((state_q == ST_CHAN) && busy_q && i_conv_done) begin
				o_fifo_data <= {WORD_LEAD, i_conv_data};
			end
		end
	end

	// ======================================================================
	// Temperature result slot
	// ======================================================================
	// A fresh reading beats a read in the same cycle
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			temp_q <= 12'h000;
			temp_valid_q <= 1'b0;
		end else if (temp_done) begin
			temp_q <= temp_hi_q - i_conv_data - TEMP_OFFSET;
			temp_valid_q <= 1'b1;
		end else if (pop_event && temp_valid_q) begin
			temp_valid_q <= 1'b0;
		end
	end

	// Pop goes to the buffer only when no temperature stands ahead
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fifo_pop <= 1'b0;
		end else begin
			o_fifo_pop <= pop_event && !temp_valid_q && !i_fifo_empty;
		end
	end

	// ======================================================================
	// Word offered to the link
	// ======================================================================
	// Refreshed every core cycle, also between frames; the link samples it at the first bit
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_word_q <= 16'h0000;
		end else if (temp_valid_q) begin
			tx_word_q <= {WORD_LEAD, temp_q};
		end else if (i_fifo_empty) begin
			tx_word_q <= 16'h0000;
		end else begin
			tx_word_q <= i_fifo_word;
		end
	end
endmodule

// *** include/asc_pkg.sv ***
// ==========================================================================
// Shared constants for the scan command block
// ==========================================================================
package asc_pkg;
	// ======================================================================
	// Command byte decoding
	// ======================================================================
	localparam int CMD_CONV_BIT = 7; // Set: conversion command
	localparam int CMD_SETUP_HI = 7; // Setup tag occupies bits 7:6
	localparam logic [1:0] CMD_SETUP_TAG = 2'h1; // Bits 7:6 = 01
	localparam int CONV_CHAN_LSB = 3; // Channel number field 6:3
	localparam int CONV_SWEEP_LSB = 1; // Sweep mode field 2:1
	localparam int CONV_TEMP_BIT = 0; // Temperature request bit
	localparam int SETUP_TIMING_LSB = 4; // Timing mode field 5:4
	localparam int SETUP_REF_LSB = 2; // Reference route field 3:2
	localparam int SETUP_PAIR_LSB = 0; // Pair config field 1:0

	// ======================================================================
	// Reset values
	// ======================================================================
	localparam logic [1:0] TIMING_RESET = 2'h2; // Upper bit set at power-up
	localparam logic [1:0] REF_RESET = 2'h0; // Internal for both
	localparam logic [1:0] PAIR_RESET = 2'h0;
	localparam logic [3:0] CHAN_RESET = 4'h0;
	localparam logic [1:0] SWEEP_RESET = 2'h0;

	// ======================================================================
	// Mode encodings
	// ======================================================================
	localparam logic [1:0] TIMING_INT_AUTO = 2'h0; // Internal acquisition
	localparam logic [1:0] TIMING_INT_PIN = 2'h1; // Acquisition by start pin
	localparam logic [1:0] TIMING_INT_CMD = 2'h2; // Started by command
	localparam logic [1:0] TIMING_EXT = 2'h3; // Serial clock timing
	localparam logic [1:0] REF_INT_BOTH = 2'h0;
	localparam logic [1:0] REF_EXT_SINGLE = 2'h1;
	localparam logic [1:0] REF_INT_ADC = 2'h2;
	localparam logic [1:0] REF_EXT_DIFF = 2'h3;
	localparam logic [1:0] SWEEP_UP_TO_N = 2'h0;
	localparam logic [1:0] SWEEP_N_TO_TOP = 2'h1;
	localparam logic [1:0] SWEEP_REPEAT = 2'h2;
	localparam logic [1:0] SWEEP_ONCE = 2'h3;

	// ======================================================================
	// Timing and counts
	// ======================================================================
	localparam logic [7:0] REF_WAKE_CYCLES = 8'hF4; // 244 conversion clocks
	localparam logic [4:0] REPEAT_0 = 5'h04; // Repeat counts per code
	localparam logic [4:0] REPEAT_1 = 5'h08;
	localparam logic [4:0] REPEAT_2 = 5'h0C;
	localparam logic [4:0] REPEAT_3 = 5'h10;
	localparam logic [11:0] TEMP_OFFSET = 12'h888; // Kelvin to Celsius shift
	localparam logic [3:0] WORD_LEAD = 4'h0; // Zero nibble ahead of data
	localparam logic [4:0] LINK_BYTE_LAST = 5'h07; // Last bit of command byte
	localparam logic [4:0] LINK_WORD_LAST = 5'h0F; // Last bit of result word
endpackage

// *** hdl/asc_serial_link.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Serial link end: runs on the host serial clock
// ==========================================================================
module asc_serial_link
	import asc_pkg::*;
(
	input wire logic i_link_clk,
	input wire logic i_reset_n,
	input wire logic i_cs_n,
	input wire logic i_din,
	input wire logic [15:0] i_tx_word,
	output logic o_dout,
	output logic [7:0] o_rx_byte,
	output logic o_rx_toggle,
	output logic o_pop_toggle
);
	logic [4:0] bit_cnt_q; // Bit position within frame
	logic [7:0] rx_shift_q; // Incoming command bits
	logic [15:0] tx_shift_q; // Outgoing result bits
	logic [7:0] rx_byte_q; // Held until next frame's byte
	logic rx_toggle_q; // Flips per command byte
	logic pop_toggle_q; // Flips per word read out

	// ======================================================================
	// Frame counter: chip select high clears it, clock may stop outside
	// ======================================================================
	always_ff @(negedge i_link_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt_q <= 5'h00;
		end else if (bit_cnt_q != 5'h1F) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// Input bits taken on falling edge; output word loaded at first bit
	always_ff @(negedge i_link_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_shift_q <= 8'h00;
			tx_shift_q <= 16'h0000;
		end else begin
			rx_shift_q <= {rx_shift_q[6:0], i_din};
			if (bit_cnt_q == 5'h00) begin
				tx_shift_q <= {i_tx_word[14:0], 1'b0};
			end else begin
				tx_shift_q <= {tx_shift_q[14:0], 1'b0};
			end
		end
	end

	// Events toggle so that the core can see them across domains
	always_ff @(negedge i_link_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_byte_q <= 8'h00;
			rx_toggle_q <= 1'b0;
			pop_toggle_q <= 1'b0;
		end else begin
			if (bit_cnt_q == LINK_BYTE_LAST) begin
				rx_byte_q <= {rx_shift_q[6:0], i_din};
				rx_toggle_q <= ~rx_toggle_q;
			end
			// Word counted as read only once all 16 bits left
			if (bit_cnt_q == LINK_WORD_LAST) begin
				pop_toggle_q <= ~pop_toggle_q;
			end
		end
	end

	// First bit comes straight from the held word, MSB first
	assign o_dout = (bit_cnt_q == 5'h00) ? i_tx_word[15] : tx_shift_q[15];
	assign o_rx_byte = rx_byte_q;
	assign o_rx_toggle = rx_toggle_q;
	assign o_pop_toggle = pop_toggle_q;
endmodule

// *** sim/asc_scan_control_props.sv ***
`timescale 1ns/10ps
// ======================================
// Port checks beside the scan command block
module asc_scan_props #(
	parameter int NUM_CHANNELS = 16
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_bandgap_force_on,
	input wire logic i_dac_ref_demand,
	input wire logic i_conv_done,
	input wire logic [11:0] i_conv_data,
	input wire logic o_osc_enable,
	input wire logic o_ext_clock_timing,
	input wire logic o_convert_start_pin_active,
	input wire logic o_adc_ref_internal,
	input wire logic o_adc_ref_secondary,
	input wire logic o_adc_ref_differential,
	input wire logic o_dac_ref_external,
	input wire logic o_secondary_pin_is_input,
	input wire logic o_ref_keep_on,
	input wire logic o_conv_start,
	input wire logic [3:0] o_conv_channel,
	input wire logic o_conv_diff,
	input wire logic o_conv_temp,
	input wire logic o_temp_bias_high,
	input wire logic o_fifo_push,
	input wire logic [15:0] o_fifo_data
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic hi_q; // Last request was the high-bias step
	// Remembers the bias of the last request, so its done can be judged
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) hi_q <= 1'b0;
		else if (o_conv_start) hi_q <= o_conv_temp & o_temp_bias_high;
	end
	sequence s_hi_done; hi_q && i_conv_done; endsequence
	sequence s_lo_start; o_conv_start && o_conv_temp && !o_temp_bias_high; endsequence
	a_temp_bias_order: assert property (s_hi_done |=> s_lo_start)
		else $error("low bias step missing");
	a_osc_mode: assert property (o_osc_enable == !o_ext_clock_timing)
		else $error("oscillator and clock mode disagree");
	a_pin_role: assert property (o_ext_clock_timing |-> !o_convert_start_pin_active)
		else $error("start pin held in serial timing");
	a_keep_on: assert property (o_ref_keep_on == (i_bandgap_force_on ||
		(o_adc_ref_internal && !o_dac_ref_external && i_dac_ref_demand)))
		else $error("reference keep-on wrong");
	a_sec_pin: assert property (o_secondary_pin_is_input ==
		!(o_adc_ref_secondary || o_adc_ref_differential)) else $error("secondary pin role wrong");
	a_push_word: assert property (o_fifo_push |-> $past(i_conv_done) &&
		o_fifo_data == {4'h0, $past(i_conv_data)}) else $error("pushed word wrong");
	a_start_once: assert property (o_conv_start |=> !o_conv_start)
		else $error("start longer than one cycle");
	a_diff_even: assert property (o_conv_start && o_conv_diff |-> !o_conv_channel[0])
		else $error("pair request on odd channel");
	a_chan_range: assert property (o_conv_start && !o_conv_temp |->
		o_conv_channel < NUM_CHANNELS) else $error("channel beyond variant");
endmodule
bind asc_scan_control asc_scan_props #(.NUM_CHANNELS(NUM_CHANNELS)) chk (.*);

// *** sim/asc_host_model.sv ***
`timescale 1ns/10ps
// ======================================
// Serial host; its clock stands still between frames
module asc_host_model (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din,
	input wire logic i_dout
);
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b0;
		o_din = 1'b0;
		// Rising select clears the link counter before any frame
		#1 o_cs_n = 1'b1;
	end
	// One frame: command byte out, result word in, both MSB first
	task automatic frame(input logic [7:0] cmd, output logic [15:0] word);
		logic [15:0] tx;
		tx = {cmd, 8'h00};
		#37 o_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			o_din = tx[i];
			#40 word[i] = i_dout;
			// 6.25 MHz, inside the read ceiling
			#40 o_sclk = 1'b0;
			#80 o_sclk = 1'b1;
		end
		#80 o_cs_n = 1'b1;
		o_din = ~o_din; // Released line must not keep its last level
	endtask
endmodule

// *** sim/asc_scan_control_tb.sv ***
`timescale 1ns/10ps
// ======================================
// Bench for the scan command block
module asc_scan_control_tb
	import asc_pkg::*;
;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", n, e, s); end end
	logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_convert_start_pin_n = 1'b1;
	logic i_bandgap_force_on = 1'b0, i_dac_ref_demand = 1'b1, i_conv_done = 1'b0;
	logic i_sclk, i_cs_n, i_din, o_dout, i_fifo_empty = 1'b1;
	logic [1:0] i_repeat_count = 2'h0, o_pair_config;
	logic [7:0] i_pair_enable = 8'h00;
	logic [11:0] i_conv_data = 12'h000, thi = 12'h900;
	logic [15:0] i_fifo_word = 16'h0000, o_fifo_data, w;
	logic [3:0] o_conv_channel;
	logic o_osc_enable, o_ext_clock_timing, o_convert_start_pin_active, o_acq_by_pin;
	logic o_adc_ref_internal, o_adc_ref_secondary, o_adc_ref_differential, o_dac_ref_external;
	logic o_secondary_pin_is_input, o_ref_keep_on, o_conv_start, o_conv_diff, o_conv_temp;
	logic o_temp_bias_high, o_fifo_push, o_fifo_pop, o_busy;
	logic [6:0] sq[$]; // Requests seen: temp, bias, pair, channel
	logic [15:0] q[$]; // Stand-in result buffer
	int n_mismatch = 0, check_count = 0, dly = 0, n;
	asc_scan_control #(.NUM_CHANNELS(16)) uut (.*);
	asc_host_model host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din), .i_dout(o_dout));
	initial forever #10 i_core_clk = ~i_core_clk;
	// Converter answers four cycles after each request; buffer follows push and pop
	always @(negedge i_core_clk) begin
		i_conv_done <= (dly == 1);
		if (dly > 0) dly <= dly - 1;
		if (o_conv_start) begin
			sq.push_back({o_conv_temp, o_temp_bias_high, o_conv_diff, o_conv_channel});
			i_conv_data <= !o_conv_temp ? {o_conv_channel, 8'h5A} : o_temp_bias_high ? thi : 12'h010;
			dly <= 4;
		end
		if (o_fifo_push) q.push_back(o_fifo_data);
		if (o_fifo_pop && q.size() > 0) void'(q.pop_front());
		i_fifo_empty <= (q.size() == 0);
		i_fifo_word <= (q.size() > 0) ? q[0] : 16'h0000;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Bounded wait until the scan is over
	task automatic settle();
		n = 0;
		repeat (10) @(negedge i_core_clk);
		while (o_busy !== 1'b0) begin
			@(negedge i_core_clk);
			n++;
			if (n > 4000) begin
				`CHK("timeout", 1'b0, 1'b1)
				wrap_up();
			end
		end
	endtask
	task automatic send(input logic [7:0] c);
		host.frame(c, w);
		settle();
	endtask
	// Every timing mode against every reference route
	task automatic t_setup();
		`CHK("reset", 3'b100, {o_osc_enable, o_ext_clock_timing, o_convert_start_pin_active})
		for (int k = 0; k < 16; k++) begin
			send({2'b01, k[3:0], k[1:0]});
			`CHK("clock", {k[3:2] != 3, k[3:2] == 3, k[3:2] < 2, k[3:2] == 1}, {o_osc_enable, o_ext_clock_timing, o_convert_start_pin_active, o_acq_by_pin})
			`CHK("ref", {!k[0], k[1:0] == 1, k[1:0] == 3, k[1:0] != 0, !k[0], k[1:0] == 0, k[1:0]}, {o_adc_ref_internal, o_adc_ref_secondary, o_adc_ref_differential, o_dac_ref_external, o_secondary_pin_is_input, o_ref_keep_on, o_pair_config})
		end
		i_bandgap_force_on = 1'b1;
		repeat (2) @(negedge i_core_clk);
		`CHK("force", 1'b1, o_ref_keep_on)
		i_bandgap_force_on = 1'b0;
		$display("setup test done");
	endtask
	task automatic t_scan(input logic [7:0] c, input int cnt, input logic [6:0] first);
		sq.delete();
		q.delete();
		send(c);
		`CHK("count", cnt, sq.size())
		`CHK("first", first, sq[0])
		$display("scan test done");
	endtask
	// Temperature taken after a reference wake is read ahead of the buffered channel word
	task automatic t_temp();
		send(8'h9F);
		thi = 12'h950;
		sq.delete();
		i_dac_ref_demand = 1'b0;
		host.frame(8'h9F, w);
		n = 0;
		while (sq.size() == 0 && n < 400) begin
			@(negedge i_core_clk);
			n++;
		end
		`CHK("wake", 1'b1, n > 150 && n < 300)
		settle();
		`CHK("order", {2'b11, 2'b10, 7'h03}, {sq[0][6:5], sq[1][6:5], sq[2]})
		send(8'h00);
		`CHK("temp", {4'h0, 12'h950 - 12'h010 - TEMP_OFFSET}, w)
		send(8'h00);
		`CHK("word", 16'h035A, w)
		$display("temp test done");
	endtask
	// Pin-started scan skips the channel lent to the pin
	task automatic t_pin();
		send(8'h40);
		sq.delete();
		host.frame(8'hF2, w);
		repeat (10) @(negedge i_core_clk);
		`CHK("write start", 0, sq.size())
		i_convert_start_pin_n = 1'b0;
		repeat (3) @(negedge i_core_clk);
		i_convert_start_pin_n = 1'b1;
		settle();
		`CHK("pin scan", 1, sq.size())
		$display("pin test done");
	endtask
	initial begin
		repeat (10) @(negedge i_core_clk);
		i_reset_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
		t_setup();
		send(8'h60);
		t_scan(8'hAE, 1, 7'h05);
		t_scan(8'h98, 4, 7'h00);
		t_scan(8'hEA, 3, 7'h0D);
		i_repeat_count = 2'h1;
		t_scan(8'hCC, 8, 7'h09);
		i_pair_enable = 8'h02;
		t_scan(8'h9E, 1, 7'h12);
		i_pair_enable = 8'h00;
		t_temp();
		t_pin();
		wrap_up();
	end
endmodule
